// ### logic/mrp_pkg.sv
/*
  Package for the mode-register programming block: pin bundle, field
  positions, register select codes and decode constants.
  Assumes one command clock sampled by the block's own 200 MHz clock.
*/
`default_nettype none
package mrp_pkg;
  // ************************************************************
  // sizes and select codes
  // ************************************************************
  localparam int          MR_COUNT  = 7;
  localparam int          MR_WIDTH  = 18;
  localparam logic [2:0]  SEL_MR0   = 3'h0;
  localparam logic [2:0]  SEL_EXT   = 3'h7;
  localparam logic [17:0] MR_RESET  = 18'h0_0000;

  // ************************************************************
  // field positions of mode_reg_zero, of the termination field and of the on-the-fly address bit
  // ************************************************************
  localparam int WR_LSB     = 9;
  localparam int DLLRST_BIT = 8;
  localparam int TM_BIT     = 7;
  localparam int BT_BIT     = 3;
  localparam int OTF_BIT    = 12;
  localparam int RTT_LSB    = 8;

  // ************************************************************
  // burst length codes
  // ************************************************************
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;

  typedef struct packed {
    logic        linkClk;
    logic        cke;
    logic        csN;
    logic        actN;
    logic        rasN;
    logic        casN;
    logic        weN;
    logic        termCtl;
    logic [1:0]  bg;
    logic [1:0]  ba;
    logic [17:0] addr;
  } mrp_pins_t;

  typedef struct packed {
    logic [1:0] burstLen;
    logic       burstIlv;
    logic [4:0] casLat;
    logic [4:0] wrRec;
    logic [4:0] rtpCnt;
    logic       testMode;
  } mrp_mode_t;
endpackage
`default_nettype wire

// ### logic/mrp_mode_regs.sv
/*
  Mode-register bank of the memory device: seven registers written by
  mode_register_set_cmd over bank-group, bank and address pins.
  Assumes the command pins and their clock come from outside this clock
  domain; the link clock runs slow enough to be edge-detected at 200 MHz.
*/
// Functional notes
// RL1: seven mode registers change only on a set command aimed at them
// RL2: controller writes all registers after reset before normal use
// RL3: controller drives every field of the chosen register on each write
// RL4: set commands and loop reset never touch stored array data
// RL5: controller spaces two set commands by mrs_to_mrs_delay, listed exceptions aside
// RL6: after input-behaviour changes controller waits for the update to finish
// RL7: controller waits mrs_to_other_cmd_delay before non-set, non-deselect commands
// RL8: listed slow functions follow their own longer update procedure
// RL9: set commands only when idle: banks precharged, bursts done, clock enable high
// RL10: termination pin low at set command when nominal termination is involved
// RL11: termination pin ignored at set command if termination disabled before and after
// RL12: controller drives reserved bits of register zero to zero
// RL13: group bit plus bank bits select registers zero to six
// RL14: register zero bits 11:9 set write recovery and read-to-precharge
// RL15: register zero bit 8 set requests a loop reset
// RL16: register zero bit 7 selects normal or test operation
// RL17: register zero bit 3 selects sequential or interleaved bursts
// RL18: register zero bits 1:0 select burst length mode
// RL19: write recovery code decodes 10 to 24, read-to-precharge half of it
// RL20: latency code decodes 9 to 16, then 18 to 24 in steps of two
// RL21: with on-the-fly bursts, bit 12 at read or write picks chop or eight
// RL22: select code 111 is ignored with no response
// RL23: controller never writes reserved codes; the testbench writes recovery code 111 and latency codes 1100 to 1111
`timescale 1ns/1ps
`default_nettype none
module mrp_mode_regs
  import mrp_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire mrp_pins_t  pins,
  output mrp_mode_t       mode_r,
  output logic [17:0]     mr0Value_r,
  output logic            mrsSeen_r,
  output logic            dllRst_r,
  output logic            accessStb_r,
  output logic            chopThis_r,
  output logic            termOn_r
);
  // ************************************************************
  // decode functions
  // ************************************************************
  function automatic logic [4:0] wrDecode(input logic [2:0] code);
    case (code)
      3'h6:    wrDecode = 5'd24;
      3'h7:    wrDecode = 5'd0;
      default: wrDecode = 5'd10 + {1'b0, code, 1'b0};
    endcase
  endfunction

  function automatic logic [4:0] casDecode(input logic [3:0] code);
    if (!code[3]) begin
      casDecode = 5'd9 + {2'b00, code[2:0]};
    end else if (!code[2]) begin
      casDecode = 5'd18 + {2'b00, code[1:0], 1'b0};
    end else begin
      casDecode = 5'd0;
    end
  endfunction

  // ************************************************************
  // pin synchronisers and link clock edge
  // ************************************************************
  mrp_pins_t pinsS1_r;
  mrp_pins_t pinsS2_r;
  logic      linkPrev_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pinsS1_r   <= '0;
      pinsS2_r   <= '0;
      linkPrev_r <= 1'b0;
    end else begin
      pinsS1_r   <= pins;
      pinsS2_r   <= pinsS1_r;
      linkPrev_r <= pinsS2_r.linkClk;
    end
  end

  wire        linkRise = pinsS2_r.linkClk & ~linkPrev_r;
  wire        selected = linkRise & ~pinsS2_r.csN & pinsS2_r.cke;
  wire        mrsAny   = selected & pinsS2_r.actN & ~pinsS2_r.rasN & ~pinsS2_r.casN & ~pinsS2_r.weN;
  wire        rdWrCmd  = selected & pinsS2_r.actN & pinsS2_r.rasN & ~pinsS2_r.casN;
  wire [2:0]  mrSel    = {pinsS2_r.bg[0], pinsS2_r.ba};
  wire        mrsHit   = mrsAny & (mrSel != SEL_EXT); // RL22
  wire [17:0] addrIn   = pinsS2_r.addr;

  // ************************************************************
  // seven mode registers
  // ************************************************************
  logic [17:0] mrBank_r [MR_COUNT];

  genvar gi;
  generate
    for (gi = 0; gi < MR_COUNT; gi++) begin : g_mr
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          mrBank_r[gi] <= MR_RESET;
        end else if (mrsHit && mrSel == 3'(gi)) begin
          mrBank_r[gi] <= addrIn; // RL1 RL13
        end
      end
    end
  endgenerate

  // no array port exists here: a set command or loop reset only touches mode state RL4

  // ************************************************************
  // register zero decode
  // ************************************************************
  wire        mr0Load  = mrsHit & (mrSel == SEL_MR0);
  wire [2:0]  wrCode   = addrIn[WR_LSB +: 3];
  wire [3:0]  casCode  = {addrIn[6:4], addrIn[2]};
  wire [4:0]  wrNxt    = wrDecode(wrCode); // RL19
  wire mrp_mode_t modeNxt;

  assign modeNxt.burstLen = addrIn[1:0]; // RL18
  assign modeNxt.burstIlv = addrIn[BT_BIT]; // RL17
  assign modeNxt.casLat   = casDecode(casCode); // RL20
  assign modeNxt.wrRec    = wrNxt; // RL14
  assign modeNxt.rtpCnt   = {1'b0, wrNxt[4:1]}; // RL19
  assign modeNxt.testMode = addrIn[TM_BIT]; // RL16

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_r     <= '0;
      mr0Value_r <= MR_RESET;
    end else if (mr0Load) begin
      mode_r     <= modeNxt;
      mr0Value_r <= addrIn;
    end
  end

  // ************************************************************
  // command side effects
  // ************************************************************
  // chop when fixed four, or when on-the-fly and bit 12 low
  wire chopNxt = (mode_r.burstLen == BL_FIXED4) |
                 ((mode_r.burstLen == BL_OTF) & ~addrIn[OTF_BIT]);
  // termination setting before and after this command
  wire rttBefore = |mrBank_r[1][RTT_LSB +: 3];
  wire rttAfter  = (mrsHit && mrSel == 3'h1) ? |addrIn[RTT_LSB +: 3] : rttBefore;
  // pin is a don't care at a set command when termination stays disabled
  wire termNxt   = (mrsAny & ~rttBefore & ~rttAfter) ? 1'b0 : (rttAfter & pinsS2_r.termCtl);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mrsSeen_r   <= 1'b0;
      dllRst_r    <= 1'b0;
      accessStb_r <= 1'b0;
      chopThis_r  <= 1'b0;
      termOn_r    <= 1'b0;
    end else begin
      mrsSeen_r   <= mrsHit;
      dllRst_r    <= mr0Load & addrIn[DLLRST_BIT]; // RL15
      accessStb_r <= rdWrCmd;
      if (rdWrCmd) begin
        chopThis_r <= chopNxt; // RL21
      end
      if (linkRise) begin
        termOn_r <= termNxt; // RL11
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence mr0WriteSeq;
    mr0Load;
  endsequence

  sequence dllReqSeq;
    mr0Load && addrIn[DLLRST_BIT];
  endsequence

  mr0_hold_a: assert property (!mr0Load |=> $stable(mr0Value_r)) // RL1
    else $error("register zero changed without a set command");
  mr0_load_a: assert property (mr0WriteSeq |=> mr0Value_r == $past(addrIn)) // RL1
    else $error("register zero did not take the address value");
  ext_ignore_a: assert property (mrsAny && mrSel == SEL_EXT |=> !mrsSeen_r && $stable(mr0Value_r)) // RL22
    else $error("select 111 was answered");
  wr_decode_a: assert property ((mr0WriteSeq and wrCode == 3'h6) |=> mode_r.wrRec == 5'd24 && mode_r.rtpCnt == 5'd12) // RL19
    else $error("write recovery code 110 misdecoded");
  wr_low_a: assert property ((mr0WriteSeq and wrCode == 3'h0) |=> mode_r.wrRec == 5'd10 && mode_r.rtpCnt == 5'd5) // RL14
    else $error("write recovery code 000 misdecoded");
  cas_decode_a: assert property ((mr0WriteSeq and casCode == 4'hb) |=> mode_r.casLat == 5'd24) // RL20
    else $error("latency code 1011 misdecoded");
  cas_first_a: assert property ((mr0WriteSeq and casCode == 4'h0) |=> mode_r.casLat == 5'd9) // RL20
    else $error("latency code 0000 misdecoded");
  sel_pulse_a: assert property (mrsHit |=> mrsSeen_r ##1 !mrsSeen_r) // RL13
    else $error("accepted set command not flagged once");
  mr1_load_a: assert property (mrsHit && mrSel == 3'h1 |=> mrBank_r[1] == $past(addrIn)) // RL13
    else $error("register one did not take the address value");
  dll_none_a: assert property (mr0Load && !addrIn[DLLRST_BIT] |=> !dllRst_r) // RL15
    else $error("loop reset raised without request");
  fixed_four_a: assert property (rdWrCmd && mode_r.burstLen == BL_FIXED4 |=> chopThis_r) // RL18
    else $error("fixed four burst not chopped");
  dll_pulse_a: assert property (dllReqSeq |=> dllRst_r ##1 !dllRst_r) // RL15
    else $error("loop reset request is not a single pulse");
  test_mode_a: assert property (mr0WriteSeq |=> mode_r.testMode == $past(addrIn[TM_BIT])) // RL16
    else $error("test mode bit not taken");
  burst_type_a: assert property (mr0WriteSeq |=> mode_r.burstIlv == $past(addrIn[BT_BIT])) // RL17
    else $error("burst type bit not taken");
  chop_otf_a: assert property (rdWrCmd && mode_r.burstLen == BL_OTF |=> chopThis_r == !$past(addrIn[OTF_BIT])) // RL21
    else $error("on-the-fly burst choice wrong");
  fixed_eight_a: assert property (rdWrCmd && mode_r.burstLen == BL_FIXED8 |=> !chopThis_r) // RL18
    else $error("fixed eight burst was chopped");
  term_ignore_a: assert property (mrsAny && !rttBefore && !rttAfter |=> !termOn_r) // RL11
    else $error("termination pin honoured while disabled");
endmodule
`default_nettype wire

// ### testbench/mrp_ctl_model.sv
/*
  Memory controller model: drives command, select and address pins.
  Assumes the caller waits for each task to return before the next command.
*/
`timescale 1ns/1ps
`default_nettype none
module mrp_ctl_model
  import mrp_pkg::*;
(
  input  wire logic ref_clk,
  output mrp_pins_t pins
);
  // ************************************************************
  // command frames
  // ************************************************************
  initial begin
    pins = '0;
    pins.cke = 1'b1;
    pins.csN = 1'b1;
  end

  // link clock only toggles inside a frame; released lines show inverse
  task automatic cmd(input logic [2:0] sel, input logic [17:0] a, input logic [3:0] op, input logic term);
    @(posedge ref_clk);
    pins.csN <= 1'b0;
    {pins.actN, pins.rasN, pins.casN, pins.weN} <= op;
    {pins.bg[0], pins.ba} <= sel;
    pins.bg[1] <= 1'b0;
    pins.addr <= a;
    pins.termCtl <= term;
    repeat (6) @(posedge ref_clk);
    pins.linkClk <= 1'b1;
    repeat (7) @(posedge ref_clk);
    pins.linkClk <= 1'b0;
    pins.csN <= 1'b1;
    pins.addr <= ~a;
    pins.termCtl <= ~term;
    // gap covers set-to-set and set-to-other spacing
    repeat (8) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// ### testbench/tb.sv
/*
  Testbench for the mode-register bank: set and read commands with checks.
  Assumes the controller model drives all pins; outputs settle within a frame.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errCount++; \
  $display("[ERR] %0t got %0h expected %0h", $time, g, e); end end
module tb;
  import mrp_pkg::*;
  // ************************************************************
  // clock, reset, design and model
  // ************************************************************
  localparam logic [3:0] OP_SET = 4'h8;
  localparam logic [3:0] OP_RD  = 4'hd;
  logic        ref_clk = 1'b0;
  logic        reset   = 1'b1;
  mrp_pins_t   pins;
  mrp_mode_t   mode_r;
  logic [17:0] mr0Value_r, w;
  logic        mrsSeen_r, dllRst_r, accessStb_r, chopThis_r, termOn_r;
  int          errCount = 0, compares = 0, mrsCnt = 0, dllCnt = 0, accCnt = 0, wrE, casE;

  always #2.5 ref_clk = ~ref_clk;

  mrp_ctl_model ctl_u (.ref_clk(ref_clk), .pins(pins));
  mrp_mode_regs dut_u (.ref_clk(ref_clk), .reset(reset), .pins(pins), .mode_r(mode_r),
    .mr0Value_r(mr0Value_r), .mrsSeen_r(mrsSeen_r), .dllRst_r(dllRst_r),
    .accessStb_r(accessStb_r), .chopThis_r(chopThis_r), .termOn_r(termOn_r));

  // pulses are counted so checks need not hit their single cycle
  always @(posedge ref_clk) begin
    if (mrsSeen_r === 1'b1) mrsCnt++;
    if (dllRst_r === 1'b1) dllCnt++;
    if (accessStb_r === 1'b1) accCnt++;
  end

  task automatic results();
    $display("compares %0d errors %0d", compares, errCount);
    if (errCount == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // write-recovery bits = i mod 8, latency bits = i, burst length = i mod 3
  function automatic logic [17:0] mr0Word(input int i, input logic [1:0] bl);
    logic [3:0] c;
    c = 4'(i);
    return {6'h00, c[2:0], c[0], c[1], c[3:1], c[2], c[0], bl};
  endfunction

  initial begin
    repeat (20000) @(posedge ref_clk);
    errCount++;
    results();
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK(mr0Value_r, 18'h0_0000)
    for (int i = 0; i < 16; i++) begin
      w = mr0Word(i, 2'(i % 3));
      ctl_u.cmd(SEL_MR0, w, OP_SET, 1'b0);
      wrE = (i % 8 == 7) ? 0 : (i % 8 == 6) ? 24 : 10 + 2 * (i % 8);
      casE = (i < 8) ? 9 + i : (i < 12) ? 18 + 2 * (i - 8) : 0;
      `CHK(mr0Value_r, w)
      `CHK(mode_r.wrRec, 5'(wrE))
      `CHK(mode_r.rtpCnt, 5'(wrE / 2))
      `CHK(mode_r.casLat, 5'(casE))
      `CHK(mode_r.testMode, w[TM_BIT])
      `CHK(mode_r.burstIlv, w[BT_BIT])
      `CHK(mode_r.burstLen, w[1:0])
      `CHK(dllCnt, (i + 1) / 2)
      `CHK(mrsCnt, i + 1)
    end
    for (int s = 1; s < 8; s++) ctl_u.cmd(3'(s), 18'h2_a0a5, OP_SET, 1'b1);
    `CHK(mr0Value_r, w)
    `CHK(mrsCnt, 22)
    ctl_u.cmd(3'h1, 18'h0_0000, OP_SET, 1'b1);
    `CHK(termOn_r, 1'b0)
    ctl_u.cmd(3'h1, 18'h0_0100, OP_SET, 1'b0);
    ctl_u.cmd(3'h0, 18'h0_0000, OP_RD, 1'b1);
    `CHK(termOn_r, 1'b1)
    for (int k = 0; k < 4; k++) begin
      ctl_u.cmd(SEL_MR0, mr0Word(0, (k < 2) ? BL_OTF : (k == 2) ? BL_FIXED8 : BL_FIXED4), OP_SET, 1'b0);
      ctl_u.cmd(3'h0, {5'h00, k[0], 12'h000}, OP_RD, 1'b0);
      `CHK(chopThis_r, (k == 0 || k == 3))
      `CHK(accCnt, k + 2)
    end
    results();
  end
endmodule
`default_nettype wire
